// ### frame_sync_event_generator_tb_top.sv
`timescale 1ns/1ps
module frame_sync_event_generator_tb_top;
  localparam int DIV = 1;
  logic        aclk = 1'b0, aresetn = 1'b0, alt_frame_pulse_pin = 1'b0;
  logic [8:0]  s_axi_awaddr = 9'h000, s_axi_araddr = 9'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d, v;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, aif_frame_sync, receive_accelerator_tick, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        intc3_event_out6, intc3_event_out7;
  logic        packet_fifo0_event, packet_fifo1_event, packet_fifo2_event;
  logic [29:0] timing_event, intc_event, te_prev = 30'h0;
  logic [63:0] dma_trigger, exp_dma;
  logic [5:0]  protocol_encoder_done_tick, protocol_encoder_frame_sync;
  logic [23:0] transmit_mac_delta, receive_mac_pi;
  logic [31:0] seed = 32'h067a30b7;
  int          n_errors = 0, samples_checked = 0, cyc = 0;
  int          off [30], per [30], first_t [30], last_t [30];
  bit          mon = 1'b0;
  always #2.5 aclk = ~aclk;
  fsevg_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .alt_frame_pulse_pin, .intc3_event_out6, .intc3_event_out7,
    .packet_fifo0_event, .packet_fifo1_event, .packet_fifo2_event,
    .timing_event, .intc_event, .dma_trigger, .aif_frame_sync,
    .receive_accelerator_tick, .protocol_encoder_done_tick,
    .protocol_encoder_frame_sync, .transmit_mac_delta, .receive_mac_pi, .irq);
  fsevg_dma_model far (.aclk, .aresetn, .dma_trigger, .intc3_event_out6,
    .intc3_event_out7, .packet_fifo0_event, .packet_fifo1_event,
    .packet_fifo2_event);
////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input string nm, input logic [63:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    $display("mismatches %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic wr(input int unsigned a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= 9'(a);
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask : wr
  task automatic rd(input int unsigned a);
    @(posedge aclk);
    s_axi_araddr  <= 9'(a);
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd_d = s_axi_rdata;
    rsp  = s_axi_rresp;
  endtask : rd
  task automatic pulse();
    @(posedge aclk);
    alt_frame_pulse_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    alt_frame_pulse_pin <= 1'b0;
  endtask : pulse
////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cyc++;
    if (aresetn) begin
      exp_dma = 64'h0;
      exp_dma[25:16] = timing_event[13:4];
      exp_dma[27:26] = {intc3_event_out7, intc3_event_out6};
      exp_dma[42:40] = {packet_fifo2_event, packet_fifo1_event,
                        packet_fifo0_event};
      chk("dma_trigger", exp_dma, dma_trigger);
      chk("intc_event", timing_event, intc_event);
      chk("hardwired", {timing_event[1], timing_event[4], timing_event[29:18]},
        {aif_frame_sync, receive_accelerator_tick, protocol_encoder_frame_sync,
         protocol_encoder_done_tick});
      chk("pulse width", 30'h0, timing_event & te_prev);
      for (int g = 0; g < 30; g++) begin
        if (mon && timing_event[g]) begin
          if (last_t[g] >= 0) chk("period", per[g]*(DIV+1), cyc-last_t[g]);
          else first_t[g] = cyc;
          last_t[g] = cyc;
        end
      end
    end
    te_prev = timing_event;
    // ceiling well above the ~1k cycles the sequence needs
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
////////////////////////////////////////////////////////////////////////
  initial begin
    for (int g = 0; g < 30; g++) begin
      first_t[g] = -1;
      last_t[g]  = -1;
    end
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(fsevg_pkg::OFF_FRAME_LEN);
    chk("frame_len", fsevg_pkg::RST_FRAME_LEN, rd_d);
    rd(fsevg_pkg::OFF_CHIP_DIV);
    chk("chip_div", fsevg_pkg::RST_CHIP_DIV, rd_d);
    rd(8'h5c);
    chk("period rst", fsevg_pkg::RST_PERIOD, rd_d);
    rd(8'h30);
    chk("unmapped rd", {2'b10, 32'h0}, {rsp, rd_d});
    wr(8'h02, 32'h1);
    chk("unaligned wr", 2'b10, rsp);
    wr(fsevg_pkg::OFF_CHIP_DIV, DIV);
    wr(fsevg_pkg::OFF_FRAME_LEN, 32'h190);
    v = xs();
    wr(fsevg_pkg::OFF_TX_DELTA, v);
    chk("tx delta", v[23:0], transmit_mac_delta);
    v = xs();
    wr(fsevg_pkg::OFF_RX_PI, v);
    chk("rx pi", v[23:0], receive_mac_pi);
    for (int g = 0; g < 30; g++) begin
      off[g] = (g == 0) ? 0 : int'(xs() % 40);
      per[g] = 1 + int'(xs() % 16);
      if (g == 4) per[g] = 32;
      if (g == 5 || g >= 18) per[g] = 4;
      // once per frame: 401 chips with the frame length set above
      if (g >= 24) per[g] = 401;
      if (g == 6) per[g] = 8;
      wr(fsevg_pkg::OFF_EVT_BASE + 8*g, 32'h8000_0000 | off[g]);
      wr(fsevg_pkg::OFF_EVT_BASE + 8*g + 4, per[g]);
    end
    wr(fsevg_pkg::OFF_IRQ_MASK, 32'h3);
    wr(fsevg_pkg::OFF_CTRL, 32'h3);
    mon = 1'b1;
    pulse();
    repeat (300) @(posedge aclk);
    // free mode: a later pulse must not disturb the cadence
    pulse();
    repeat (300) @(posedge aclk);
    mon = 1'b0;
    for (int g = 0; g < 30; g++) begin
      chk("offset", off[g]*(DIV+1), first_t[g]-first_t[0]);
    end
    rd(fsevg_pkg::OFF_STATUS);
    chk("status", 32'h2, rd_d);
    rd(fsevg_pkg::OFF_IRQ_STAT);
    chk("irq stat", 2'b11, rd_d[1:0]);
    chk("irq on", 1'b1, irq);
    wr(fsevg_pkg::OFF_IRQ_MASK, 32'h0);
    chk("irq masked", 1'b0, irq);
    wr(fsevg_pkg::OFF_CTRL, 32'h0);
    repeat (8) @(posedge aclk);
    wr(fsevg_pkg::OFF_IRQ_STAT, 32'h3);
    rd(fsevg_pkg::OFF_IRQ_STAT);
    chk("irq clear", 32'h0, rd_d);
    wr(fsevg_pkg::OFF_IRQ_MASK, 32'h3);
    chk("irq off", 1'b0, irq);
    print_verdict();
  end
endmodule : frame_sync_event_generator_tb_top

// ### fsevg_dma_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// far side: router outputs and packet fifo flags, free pseudo random
module fsevg_dma_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [63:0] dma_trigger,
  output logic             intc3_event_out6,
  output logic             intc3_event_out7,
  output logic             packet_fifo0_event,
  output logic             packet_fifo1_event,
  output logic             packet_fifo2_event
);
  logic [7:0] lfsr_q;
  int         n_direct;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_q   <= 8'h5a;
      n_direct <= 0;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      // shared event starts the first link only, chain does the rest
      if (|dma_trigger[25:16]) n_direct <= n_direct + 1;
    end
  end
  // lfsr shifts every cycle so a stale pass-through cannot match for long
  assign intc3_event_out6   = lfsr_q[0];
  assign intc3_event_out7   = lfsr_q[1];
  assign packet_fifo0_event = lfsr_q[2];
  assign packet_fifo1_event = lfsr_q[3];
  assign packet_fifo2_event = lfsr_q[4];
endmodule : fsevg_dma_model

// ### fsevg_event_gen.sv
`timescale 1ns/1ps
// one event: start offset in chips after frame start, then every period
module fsevg_event_gen #(
  parameter int unsigned CNT_W      = 24,
  parameter bit          COUNT_MODE = 1'b0
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             frame_start,
  input  wire logic             chip_tick,
  input  wire logic             running,
  input  wire logic [CNT_W-1:0] offset,
  input  wire logic [CNT_W-1:0] period,
  input  wire logic             enable,
  output logic                  pulse
);
  logic [CNT_W-1:0] cnt_q;
  logic             started_q;
  logic             hit;
  logic [CNT_W-1:0] per_m1;

  assign per_m1 = (period == '0) ? '0 : period - CNT_W'(1);
  // mask scheme compares against offset then period; count scheme reloads
  assign hit = COUNT_MODE ? (started_q ? cnt_q == '0 : cnt_q == offset)
                          : (started_q ? cnt_q == per_m1 : cnt_q == offset);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q     <= '0;
      started_q <= 1'b0;
    end else if (frame_start || !running) begin
      cnt_q     <= '0;
      started_q <= 1'b0;
    end else if (chip_tick) begin
      if (hit) begin
        started_q <= 1'b1;
        cnt_q     <= COUNT_MODE ? per_m1 : '0;
      end else if (COUNT_MODE && started_q) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  // single-cycle pulse per occurrence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse <= 1'b0;
    end else begin
      pulse <= running && enable && chip_tick && hit && !frame_start; // RULE16
    end
  end

  a_pulse_single : assert property (@(posedge aclk) disable iff (!aresetn)
    pulse |=> !pulse) else $error("event pulse longer than one cycle"); // RULE16
endmodule : fsevg_event_gen

// ### fsevg_pkg.sv
package fsevg_pkg;
  localparam int unsigned NUM_EVENTS      = 30;
  localparam int unsigned CNT_W           = 24;
  localparam int unsigned CLK_HZ          = 200_000_000;
  // register byte offsets
  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_STATUS      = 8'h04;
  localparam logic [7:0]  OFF_IRQ_STAT    = 8'h08;
  localparam logic [7:0]  OFF_IRQ_MASK    = 8'h0c;
  localparam logic [7:0]  OFF_FRAME_LEN   = 8'h10;
  localparam logic [7:0]  OFF_CHIP_DIV    = 8'h14;
  localparam logic [7:0]  OFF_TX_DELTA    = 8'h18;
  localparam logic [7:0]  OFF_RX_PI       = 8'h1c;
  localparam logic [7:0]  OFF_EVT_BASE    = 8'h40;
  localparam logic [7:0]  OFF_EVT_STRIDE  = 8'h08;
  // ctrl field positions
  localparam int unsigned CTRL_RUN_BIT    = 0;
  localparam int unsigned CTRL_FREE_BIT   = 1;
  localparam int unsigned CTRL_ARM_BIT    = 2;
  // reset values
  localparam logic [31:0] RST_FRAME_LEN   = 32'h0000_95ff;
  localparam logic [31:0] RST_CHIP_DIV    = 32'h0000_0033;
  localparam logic [31:0] RST_PERIOD      = 32'h0000_0004;
  // fixed event indices, dma base, link count and periods
  localparam int unsigned EVT_AIF_FSYNC   = 1;
  localparam int unsigned EVT_RAC_TICK    = 4;
  localparam int unsigned EVT_DMA_LO      = 4;
  localparam int unsigned EVT_DMA_HI      = 13;
  localparam int unsigned DMA_DIRECT_BASE = 16;
  localparam int unsigned EVT_DONE_LO     = 18;
  localparam int unsigned EVT_PEFS_LO     = 24;
  localparam int unsigned NUM_LINKS       = 6;
  localparam int unsigned EVT_CNT_LO      = 10;
  localparam int unsigned EVT_CNT_HI      = 17;
  localparam logic [31:0] RAC_PERIOD      = 32'h0000_0020;
  localparam logic [31:0] DONE_PERIOD     = 32'h0000_0004;
  // minimum sync pulse width
  localparam int unsigned SYNC_MIN_NS     = 10;
  localparam int unsigned SYNC_MIN_CYC    =
    (SYNC_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  typedef enum logic [1:0] {FSEVG_IDLE, FSEVG_WAIT, FSEVG_RUN} fsevg_state_e;
  function automatic logic fsevg_is_count_evt(input int unsigned i);
    return (i >= EVT_CNT_LO) && (i <= EVT_CNT_HI);
  endfunction : fsevg_is_count_evt
endpackage : fsevg_pkg

// ### fsevg_top.sv
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - timing runs from the reference clock, aligned to the frame pulse
// RULE2 - thirty periodic events, each with own offset and period
// RULE3 - events 10 to 17 use count scheme, others mask scheme
// RULE4 - every event is offered to interrupt routing; only events 4 to 13 also reach dma routing
// RULE5 - software picks 4 chip downlink and 8 chip uplink periods
// RULE6 - events 4 to 13 drive dma channels 16 to 25 directly
// RULE7 - dma 26 and 27 take interrupt router outputs 6 and 7
// RULE8 - dma 40 to 42 take packet fifo 0 to 2 not-empty events
// RULE9 - event 1 is the once-per-frame interface frame sync
// RULE10 - events 18 to 23 are per-link dma-done ticks every 4 chips
// RULE11 - events 24 to 29 are per-link encoder frame syncs
// RULE12 - event 4 is the receive accelerator tick every 32 chips
// RULE13 - dma chains links sharing one event, first on the event
// RULE14 - free-running mode ignores the frame pulse after start
// RULE15 - tx mac offset from delta, rx mac offset from pi
// RULE16 - each event occurrence is a single-clock pulse
module fsevg_top #(
  parameter int unsigned NUM_EVENTS = fsevg_pkg::NUM_EVENTS,
  parameter int unsigned CNT_W      = fsevg_pkg::CNT_W
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [8:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [8:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  alt_frame_pulse_pin,
  input  wire logic                  intc3_event_out6,
  input  wire logic                  intc3_event_out7,
  input  wire logic                  packet_fifo0_event,
  input  wire logic                  packet_fifo1_event,
  input  wire logic                  packet_fifo2_event,
  output logic [NUM_EVENTS-1:0]      timing_event,
  output logic [NUM_EVENTS-1:0]      intc_event,
  output logic [63:0]                dma_trigger,
  output logic                       aif_frame_sync,
  output logic                       receive_accelerator_tick,
  output logic [5:0]                 protocol_encoder_done_tick,
  output logic [5:0]                 protocol_encoder_frame_sync,
  output logic [CNT_W-1:0]           transmit_mac_delta,
  output logic [CNT_W-1:0]           receive_mac_pi,
  output logic                       irq
);
  localparam int unsigned NL = fsevg_pkg::NUM_LINKS;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [2:0]             ctrl_q;
  logic [31:0]            frame_len_q;
  logic [15:0]            chip_div_q;
  logic [CNT_W-1:0]       delta_q;
  logic [CNT_W-1:0]       pi_q;
  logic [CNT_W-1:0]       evt_off_q [NUM_EVENTS];
  logic [CNT_W-1:0]       evt_per_q [NUM_EVENTS];
  logic [NUM_EVENTS-1:0]  evt_en_q;
  logic [1:0]             irq_stat_q;
  logic [1:0]             irq_mask_q;
  fsevg_pkg::fsevg_state_e state_q;

  logic        aw_hold_q, w_hold_q;
  logic [8:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go;
  logic [1:0]  bresp_d;

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : strb_merge

  // event registers: offset at even word, period at odd word
  // full-width compare: a truncated index aliased the low registers
  function automatic logic evt_hit(input logic [8:0] a,
                                   input int unsigned i);
    return (32'(a[8:3]) == (32'(fsevg_pkg::OFF_EVT_BASE) >> 3) + i);
  endfunction : evt_hit

  function automatic logic addr_ok(input logic [8:0] a);
    logic r;
    r = (a[1:0] == 2'h0) && (a < 9'h020);
    if (a >= 9'(fsevg_pkg::OFF_EVT_BASE)) r = (a[1:0] == 2'h0) &&
      (32'(a) < 32'(fsevg_pkg::OFF_EVT_BASE) + 32'(NUM_EVENTS) * 8);
    return r;
  endfunction : addr_ok

  ////////////////////////////////////////////////////////////////////////
  // axi write channel, address and data taken in either order
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign wr_go         = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign bresp_d       = addr_ok(awaddr_q) ? 2'b00 : 2'b10;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= 9'h000;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= bresp_d;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q      <= 3'h0;
      frame_len_q <= fsevg_pkg::RST_FRAME_LEN;
      chip_div_q  <= fsevg_pkg::RST_CHIP_DIV[15:0];
      delta_q     <= '0;
      pi_q        <= '0;
      irq_mask_q  <= 2'h0;
      evt_en_q    <= '0;
      for (int i = 0; i < NUM_EVENTS; i++) begin
        evt_off_q[i] <= '0;
        evt_per_q[i] <= CNT_W'(fsevg_pkg::RST_PERIOD);
      end
    end else if (wr_go) begin
      unique case (awaddr_q)
        fsevg_pkg::OFF_CTRL: ctrl_q <= 3'(strb_merge(32'(ctrl_q), wdata_q,
                                                     wstrb_q));
        fsevg_pkg::OFF_IRQ_MASK: irq_mask_q <= wdata_q[1:0];
        fsevg_pkg::OFF_FRAME_LEN:
          frame_len_q <= strb_merge(frame_len_q, wdata_q, wstrb_q);
        fsevg_pkg::OFF_CHIP_DIV: chip_div_q <= wdata_q[15:0];
        fsevg_pkg::OFF_TX_DELTA: delta_q <= wdata_q[CNT_W-1:0]; // RULE15
        fsevg_pkg::OFF_RX_PI:    pi_q    <= wdata_q[CNT_W-1:0]; // RULE15
        default: if (addr_ok(awaddr_q)) begin
          for (int i = 0; i < NUM_EVENTS; i++) begin
            if (evt_hit(awaddr_q, i) && !awaddr_q[2]) begin
              evt_off_q[i] <= wdata_q[CNT_W-1:0]; // RULE2
              evt_en_q[i]  <= wdata_q[31];
            end
            if (evt_hit(awaddr_q, i) && awaddr_q[2]) begin
              evt_per_q[i] <= wdata_q[CNT_W-1:0]; // RULE2
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi read channel
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (s_axi_araddr)
      fsevg_pkg::OFF_CTRL:      rd_d = 32'(ctrl_q);
      fsevg_pkg::OFF_STATUS:    rd_d = 32'(state_q);
      fsevg_pkg::OFF_IRQ_STAT:  rd_d = 32'(irq_stat_q);
      fsevg_pkg::OFF_IRQ_MASK:  rd_d = 32'(irq_mask_q);
      fsevg_pkg::OFF_FRAME_LEN: rd_d = frame_len_q;
      fsevg_pkg::OFF_CHIP_DIV:  rd_d = 32'(chip_div_q);
      fsevg_pkg::OFF_TX_DELTA:  rd_d = 32'(delta_q);
      fsevg_pkg::OFF_RX_PI:     rd_d = 32'(pi_q);
      default: begin
        for (int i = 0; i < NUM_EVENTS; i++) begin
          if (evt_hit(s_axi_araddr, i)) begin
            rd_d = s_axi_araddr[2] ? 32'(evt_per_q[i])
                 : {evt_en_q[i], 7'h00, 24'(evt_off_q[i])};
          end
        end
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= addr_ok(s_axi_araddr) ? rd_d : 32'h0000_0000;
      s_axi_rresp  <= addr_ok(s_axi_araddr) ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame timer: chip divider plus chip counter per frame
  logic        run_en, free_mode, sync_edge, frame_start, chip_tick;
  logic        pin_q;
  logic [15:0] div_q;
  logic [31:0] chip_q;

  assign run_en    = ctrl_q[fsevg_pkg::CTRL_RUN_BIT];
  assign free_mode = ctrl_q[fsevg_pkg::CTRL_FREE_BIT];
  assign sync_edge = alt_frame_pulse_pin && !pin_q;
  assign chip_tick = (state_q == fsevg_pkg::FSEVG_RUN) && (div_q == 16'h0);
  // free mode only honours the first pulse; no resync later
  assign frame_start = sync_edge && (state_q == fsevg_pkg::FSEVG_WAIT ||
                       (state_q == fsevg_pkg::FSEVG_RUN && !free_mode)); // RULE1 RULE14

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q   <= 1'b0;
      state_q <= fsevg_pkg::FSEVG_IDLE;
    end else begin
      pin_q <= alt_frame_pulse_pin;
      unique case (state_q)
        fsevg_pkg::FSEVG_IDLE: if (run_en) state_q <= fsevg_pkg::FSEVG_WAIT;
        fsevg_pkg::FSEVG_WAIT: begin
          if (!run_en) state_q <= fsevg_pkg::FSEVG_IDLE;
          else if (sync_edge) state_q <= fsevg_pkg::FSEVG_RUN; // RULE1
        end
        fsevg_pkg::FSEVG_RUN: if (!run_en) state_q <= fsevg_pkg::FSEVG_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q  <= 16'h0;
      chip_q <= 32'h0;
    end else if (frame_start || state_q != fsevg_pkg::FSEVG_RUN) begin
      div_q  <= chip_div_q;
      chip_q <= 32'h0;
    end else if (chip_tick) begin
      div_q  <= chip_div_q;
      // frame wrap restarts every event, like an internal pulse
      chip_q <= (chip_q == frame_len_q) ? 32'h0 : chip_q + 32'h1;
    end else begin
      div_q <= div_q - 16'h1;
    end
  end

  logic frame_wrap;
  logic running;
  assign frame_wrap = frame_start || (chip_tick && chip_q == frame_len_q);
  assign running    = (state_q == fsevg_pkg::FSEVG_RUN);

  ////////////////////////////////////////////////////////////////////////
  // thirty event generators
  for (genvar g = 0; g < NUM_EVENTS; g++) begin : g_evt
    fsevg_event_gen #(
      .CNT_W      (CNT_W),
      .COUNT_MODE (fsevg_pkg::fsevg_is_count_evt(g)) // RULE3
    ) u_evt (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .frame_start (frame_wrap),
      .chip_tick   (chip_tick),
      .running     (running),
      .offset      (evt_off_q[g]),
      .period      (evt_per_q[g]),
      .enable      (evt_en_q[g]),
      .pulse       (timing_event[g]) // RULE2 RULE16
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // routing
  assign intc_event = timing_event; // RULE4
  always_comb begin
    dma_trigger = 64'h0;
    for (int i = fsevg_pkg::EVT_DMA_LO; i <= fsevg_pkg::EVT_DMA_HI; i++) begin
      dma_trigger[fsevg_pkg::DMA_DIRECT_BASE + i - fsevg_pkg::EVT_DMA_LO]
        = timing_event[i]; // RULE6
    end
    dma_trigger[26] = intc3_event_out6; // RULE7
    dma_trigger[27] = intc3_event_out7; // RULE7
    dma_trigger[40] = packet_fifo0_event; // RULE8
    dma_trigger[41] = packet_fifo1_event; // RULE8
    dma_trigger[42] = packet_fifo2_event; // RULE8
  end

  assign aif_frame_sync           = timing_event[fsevg_pkg::EVT_AIF_FSYNC]; // RULE9
  assign receive_accelerator_tick = timing_event[fsevg_pkg::EVT_RAC_TICK]; // RULE12
  assign protocol_encoder_done_tick =
    timing_event[fsevg_pkg::EVT_DONE_LO +: NL]; // RULE10
  assign protocol_encoder_frame_sync =
    timing_event[fsevg_pkg::EVT_PEFS_LO +: NL]; // RULE11
  assign transmit_mac_delta = delta_q; // RULE15
  assign receive_mac_pi     = pi_q; // RULE15

  ////////////////////////////////////////////////////////////////////////
  // interrupts: bit0 frame sync seen, bit1 frame pulse while free running
  logic [1:0] irq_ev;
  logic [1:0] irq_clr;
  assign irq_ev  = {sync_edge && free_mode && running,
                    timing_event[fsevg_pkg::EVT_AIF_FSYNC]};
  assign irq_clr = (wr_go && awaddr_q == fsevg_pkg::OFF_IRQ_STAT)
                   ? wdata_q[1:0] : 2'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_stat_q <= 2'h0;
    else irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_dma_direct : assert property (@(posedge aclk) disable iff (!aresetn)
    dma_trigger[25:16] == timing_event[13:4]) // RULE6
    else $error("direct dma map broken");
  a_free_nosync : assert property (@(posedge aclk) disable iff (!aresetn)
    (running && free_mode && sync_edge) |-> !frame_start) // RULE14
    else $error("free mode resynced");
  a_sync_start : assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == fsevg_pkg::FSEVG_WAIT && run_en && sync_edge)
      |=> running) // RULE1
    else $error("did not start on pulse");
  a_fifo_route : assert property (@(posedge aclk) disable iff (!aresetn)
    dma_trigger[42:40] == {packet_fifo2_event, packet_fifo1_event,
                           packet_fifo0_event}) // RULE8
    else $error("fifo dma map broken");
  a_idle_quiet : assert property (@(posedge aclk) disable iff (!aresetn)
    !running [*2] |-> timing_event == '0) // RULE2
    else $error("event while stopped");
  a_irq_sticky : assert property (@(posedge aclk) disable iff (!aresetn)
    (irq_stat_q[0] && !irq_clr[0]) |=> irq_stat_q[0])
    else $error("status bit dropped");
  a_pe_sync : assert property (@(posedge aclk) disable iff (!aresetn)
    protocol_encoder_frame_sync == timing_event[29:24]) // RULE11
    else $error("encoder sync map broken");
  a_rac_tick : assert property (@(posedge aclk) disable iff (!aresetn)
    receive_accelerator_tick |=> !receive_accelerator_tick) // RULE12 RULE16
    else $error("rac tick too wide");
  c_frame : cover property (@(posedge aclk) frame_start);
  c_fsync : cover property (@(posedge aclk) aif_frame_sync);
  c_irq   : cover property (@(posedge aclk) irq);
endmodule : fsevg_top
